//--- bench/fetch_model.sv
/*
  fetch stage stand-in: presents one halfword per call.
  assumes the caller invokes put just after a falling clock edge.
*/
`timescale 1ns/1ps
module fetch_model (
  // halfword to decoder
  output logic        fetch_valid,
  output logic [15:0] fetch_half,
  output logic        mode64_en
);
  initial begin
    fetch_valid = 1'b0;
    fetch_half = 16'h0000;
    mode64_en = 1'b0;
  end
  // idle slots scramble the halfword so a held value cannot pass for a decode
  task automatic put(input logic v, input logic [15:0] h, input logic m);
    fetch_valid = v;
    fetch_half = v ? h : ~h;
    mode64_en = m;
  endtask : put
endmodule : fetch_model

//--- bench/halfword_decoder_monitor.sv
/*
  concurrent checks on the halfword decoder ports.
  assumes one clock, async active-low reset, one-cycle registered result.
*/
`timescale 1ns/1ps
module halfword_decoder_monitor
  import halfword_decode_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // fetch side
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_half,
  input wire logic        mode64_en,
  // decoded result
  input wire logic        dec_valid_q,
  input wire operation_e  dec_operation_q,
  input wire logic        dec_rsvd_exc_q,
  input wire logic        dec_invalid_q,
  input wire logic [4:0]  dec_full_reg_q,
  input wire logic [3:0]  dec_shift_count_q,
  input wire logic        dec_dshift_ext_q,
  input wire logic        dec_mode_switch_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==================================================================
  // result timing and flags
  valid_follow_a: assert property (fetch_valid |=> dec_valid_q)
    else $error("result valid missing");
  idle_quiet_a: assert property (!fetch_valid |=> !dec_valid_q &&
    dec_operation_q == k_none && !dec_rsvd_exc_q) else $error("idle output");
  rsvd_flag_a: assert property (dec_valid_q |->
    dec_rsvd_exc_q == (dec_operation_q == k_reserved)) else $error("rsvd flag");
  invalid_code_a: assert property (fetch_valid && fetch_half[15:11] == 5'h1d &&
    fetch_half[4:0] == 5'h09 |=> dec_invalid_q && !dec_rsvd_exc_q)
    else $error("invalid code");
  // ==================================================================
  // minor maps and fields
  rrr_addu_a: assert property (fetch_valid && mode64_en &&
    fetch_half[15:11] == 5'h1c && fetch_half[1:0] == 2'b01 |=> dec_operation_q == k_addu)
    else $error("three-reg map");
  dshift_count_a: assert property (fetch_valid && mode64_en &&
    fetch_half[15:11] == 5'h1d && fetch_half[4:0] == 5'h08 |=> dec_dshift_ext_q &&
    dec_shift_count_q == (($past(fetch_half[10:8]) == 3'h0) ? 4'h8
    : {1'b0, $past(fetch_half[10:8])})) else $error("dword shift count");
  mode_gate_a: assert property (fetch_valid && !mode64_en &&
    fetch_half[15:11] == 5'h1f |=> dec_rsvd_exc_q) else $error("imm64 not gated");
  jal_select_a: assert property (fetch_valid && fetch_half[15:11] == 5'h03
    |=> dec_mode_switch_q == $past(fetch_half[10])) else $error("jal selector");
  full_move_a: assert property (fetch_valid && fetch_half[15:8] == 8'h65
    |=> dec_full_reg_q == {$past(fetch_half[4:3]), $past(fetch_half[7:5])})
    else $error("full register number");
  // main scenarios seen
  cov_rsvd: cover property (dec_rsvd_exc_q);
  cov_inv: cover property (dec_invalid_q);
  cov_jalx: cover property (dec_mode_switch_q);
endmodule : halfword_decoder_monitor

bind halfword_decoder halfword_decoder_monitor u_halfword_decoder_monitor (.clk_sys,
  .reset_n, .fetch_valid, .fetch_half, .mode64_en, .dec_valid_q, .dec_operation_q,
  .dec_rsvd_exc_q, .dec_invalid_q, .dec_full_reg_q, .dec_shift_count_q,
  .dec_dshift_ext_q, .dec_mode_switch_q);

//--- bench/testbench.sv
/*
  self-checking bench for the halfword decoder, one task per scenario.
  assumes result appears one clock after the halfword is presented.
*/
`timescale 1ns/1ps
module testbench
  import halfword_decode_pkg::*;
;
  logic clk_sys, reset_n, fetch_valid, mode64_en, dec_valid_q, dec_rsvd_exc_q;
  logic [15:0] fetch_half;
  logic dec_invalid_q, dec_dshift_ext_q, dec_mode_switch_q;
  logic [4:0] dec_full_reg_q;
  logic [3:0] dec_shift_count_q;
  operation_e dec_operation_q;
  int errors, total_checks;
  // expected major map, then reg-reg minor map, then imm8 map
  localparam operation_e MAJ[32] = '{k_addiu_sp, k_addiu_pc, k_branch, k_jal, k_beqz,
    k_bnez, k_sll, k_ld, k_addiu_ria, k_add_imm_first_reg, k_slti, k_sltiu, k_bteqz, k_li,
    k_cmpi, k_sd, k_lb, k_lh, k_lw_sp, k_lw, k_lbu, k_lhu, k_lw_pc, k_lwu, k_sb, k_sh,
    k_sw_sp, k_sw, k_daddu, k_jump_first, k_extend, k_ld_sp};
  localparam operation_e RRM[32] = '{k_jump_first, k_reserved, k_slt, k_sltu, k_sllv,
    k_brk, k_srlv, k_srav, k_dsrl, k_invalid, k_cmp, k_neg, k_and, k_or, k_xor, k_not,
    k_mfhi, k_reserved, k_mflo, k_dsra, k_dsllv, k_reserved, k_dsrlv, k_dsrav, k_mult,
    k_multu, k_div, k_divu, k_dmult, k_dmultu, k_ddiv, k_ddivu};
  localparam operation_e I8M[8] = '{k_bteqz, k_btnez, k_sw_ra_sp, k_adj_sp, k_reserved,
    k_move_into_full_reg, k_reserved, k_move_from_full_reg};
  localparam logic [15:0] WIDE[6] = '{16'h3001, 16'h3800, 16'hb800, 16'he000,
    16'hf800, 16'h4010};

  halfword_decoder u_halfword_decoder (.clk_sys, .reset_n, .fetch_valid, .fetch_half,
    .mode64_en, .dec_valid_q, .dec_operation_q, .dec_rsvd_exc_q, .dec_invalid_q,
    .dec_full_reg_q, .dec_shift_count_q, .dec_dshift_ext_q, .dec_mode_switch_q);
  fetch_model u_fetch_model (.fetch_valid, .fetch_half, .mode64_en);

  // ==================================================================
  // compare helpers
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : ck
  // back to back: entered at a falling edge, leaves at the next one
  task automatic chk(input logic [15:0] h, input logic m, input operation_e op);
    u_fetch_model.put(1'b1, h, m);
    @(negedge clk_sys);
    ck(16'(dec_valid_q), 16'h0001);
    ck(16'(dec_operation_q), 16'(op));
    ck(16'(dec_rsvd_exc_q), 16'(op == k_reserved));
    ck(16'(dec_invalid_q), 16'(op == k_invalid));
  endtask : chk
  task automatic chk_shift(input logic [15:0] h, input operation_e op,
                           input logic [3:0] cnt, input logic ext);
    chk(h, 1'b1, op);
    ck(16'(dec_shift_count_q), 16'(cnt));
    ck(16'(dec_dshift_ext_q), 16'(ext));
  endtask : chk_shift

  // ==================================================================
  // scenarios
  task automatic major_scan();
    for (int i = 0; i < 32; i++) chk(16'(i) << 11, 1'b1, MAJ[i]);
  endtask : major_scan
  task automatic reg_reg_scan();
    for (int i = 0; i < 32; i++) begin
      chk(16'he900 | 16'(i), 1'b1, RRM[i]);
    end
    chk(16'he820, 1'b1, k_jump_ret);
    chk(16'heb20, 1'b1, k_reserved);
    chk(16'he840, 1'b1, k_jump_link);
    chk(16'he860, 1'b1, k_reserved);
  endtask : reg_reg_scan
  task automatic minor_scan();
    for (int i = 0; i < 4; i++) chk(16'he000 | 16'(i), 1'b1, operation_e'(k_daddu + i));
    for (int i = 0; i < 2; i++) begin
      chk(16'h4000 | 16'(i << 4), 1'b1, operation_e'(k_addiu_ria + i));
    end
    for (int i = 0; i < 4; i++) chk(16'h3000 | 16'(i), 1'b1, operation_e'(k_sll + i));
    for (int i = 0; i < 8; i++) chk(16'h6000 | 16'(i << 8), 1'b1, I8M[i]);
    for (int i = 0; i < 8; i++) begin
      chk(16'hf800 | 16'(i << 8), 1'b1, operation_e'(k_ld_sp + i));
    end
  endtask : minor_scan
  task automatic shift_counts();
    chk_shift(16'h300c, k_sll, 4'h3, 1'b0);
    chk_shift(16'h3003, k_sra, 4'h8, 1'b0);
    chk_shift(16'he808, k_dsrl, 4'h8, 1'b1);
    chk_shift(16'hed13, k_dsra, 4'h5, 1'b1);
    chk_shift(16'he914, k_dsllv, 4'h0, 1'b0);
  endtask : shift_counts
  task automatic full_moves();
    chk(16'h6532, 1'b1, k_move_into_full_reg);
    ck(16'(dec_full_reg_q), 16'h0011);
    chk(16'h6776, 1'b1, k_move_from_full_reg);
    ck(16'(dec_full_reg_q), 16'h0016);
  endtask : full_moves
  task automatic mode_gate();
    foreach (WIDE[i]) chk(WIDE[i], 1'b0, k_reserved);
    chk(16'h3000, 1'b0, k_sll);
  endtask : mode_gate
  task automatic jal_select();
    chk(16'h1c00, 1'b1, k_jalx);
    ck(16'(dec_mode_switch_q), 16'h0001);
    chk(16'h1800, 1'b1, k_jal);
    ck(16'(dec_mode_switch_q), 16'h0000);
  endtask : jal_select
  task automatic idle_slot();
    u_fetch_model.put(1'b0, 16'he808, 1'b1);
    @(negedge clk_sys);
    ck(16'(dec_valid_q), 16'h0000);
    ck(16'(dec_operation_q), 16'(k_none));
  endtask : idle_slot
  // async reset in mid-run: outputs clear at once, decode resumes next edge
  task automatic reset_midrun();
    chk(16'he8a0, 1'b1, k_reserved);
    reset_n = 1'b0;
    #1;
    ck(16'(dec_valid_q), 16'h0000);
    ck(16'(dec_operation_q), 16'(k_none));
    ck(16'(dec_rsvd_exc_q), 16'h0000);
    @(negedge clk_sys);
    reset_n = 1'b1;
    chk(16'he8a0, 1'b1, k_reserved);
  endtask : reset_midrun

  // ==================================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // a run needs about 120 cycles; allow far more
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    total_checks = 0;
    reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    major_scan();
    reg_reg_scan();
    minor_scan();
    shift_counts();
    full_moves();
    mode_gate();
    jal_select();
    idle_slot();
    reset_midrun();
    wrap_up();
  end
endmodule : testbench

//--- core/halfword_decoder.sv
/*
  decoder for the 16-bit compressed instruction set: major map plus the
  minor maps of the register-register, three-register, register-immediate
  add, shift, 8-bit immediate and 64-bit immediate groups.
  assumes fetch presents one halfword per cycle with a valid strobe, and
  that the execution pipeline accepts one result per cycle.
  the extend prefix is reported on its own. merging it with the next halfword,
  widening the immediate and choosing the pc base are left to the pipeline.
  the 64-bit gate is a level from outside and is not latched here.
*/
`timescale 1ns/1ps

module halfword_decoder
  import halfword_decode_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // halfword from fetch
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_half,
  input  wire logic        mode64_en,
  // decoded result to execution
  output      logic        dec_valid_q,
  output      operation_e  dec_operation_q,
  output      logic        dec_rsvd_exc_q,
  output      logic        dec_invalid_q,
  output      logic [4:0]  dec_full_reg_q,
  output      logic [3:0]  dec_shift_count_q,
  output      logic        dec_dshift_ext_q,
  output      logic        dec_mode_switch_q
);

  // ======================================================================
  // minor map functions

  // three_register_group
  function automatic operation_e decode_three_reg(input logic [15:0] h);
    operation_e r;
    case (h[SUB2_HI:SUB2_LO])
      2'h0: r = k_daddu;
      2'h1: r = k_addu;
      2'h2: r = k_dsubu;
      default: r = k_subu;
    endcase
    return r;
  endfunction : decode_three_reg

  // shift group
  function automatic operation_e decode_shift(input logic [15:0] h);
    operation_e r;
    case (h[SUB2_HI:SUB2_LO])
      2'h0: r = k_sll;
      2'h1: r = k_dsll;
      2'h2: r = k_srl;
      default: r = k_sra;
    endcase
    return r;
  endfunction : decode_shift

  // indirect_jump_group, split on the second register field
  function automatic operation_e decode_ind_jump(input logic [15:0] h);
    operation_e r;
    case (h[SECOND_HI:SECOND_LO])
      3'h0: r = k_jump_first;
      3'h1: r = (h[FIRST_HI:FIRST_LO] == 3'h0) ? k_jump_ret : k_reserved;
      3'h2: r = k_jump_link;
      default: r = k_reserved;  // undefined splits trap rather than guess
    endcase
    return r;
  endfunction : decode_ind_jump

  // reg_reg_group minor map, row in [4:3], column in [2:0]
  // three holes trap and one is tolerated; they stay distinct so the pipeline
  // raises the exception only where it belongs
  function automatic operation_e decode_reg_reg(input logic [15:0] h);
    operation_e r;
    case (h[FUNCT_HI:FUNCT_LO])
      5'h00: r = decode_ind_jump(h);
      5'h01: r = k_reserved;
      5'h02: r = k_slt;
      5'h03: r = k_sltu;
      5'h04: r = k_sllv;
      5'h05: r = k_brk;
      5'h06: r = k_srlv;
      5'h07: r = k_srav;
      5'h08: r = k_dsrl;
      5'h09: r = k_invalid;
      5'h0a: r = k_cmp;
      5'h0b: r = k_neg;
      5'h0c: r = k_and;
      5'h0d: r = k_or;
      5'h0e: r = k_xor;
      5'h0f: r = k_not;
      5'h10: r = k_mfhi;
      5'h11: r = k_reserved;
      5'h12: r = k_mflo;
      5'h13: r = k_dsra;
      5'h14: r = k_dsllv;
      5'h15: r = k_reserved;
      5'h16: r = k_dsrlv;
      5'h17: r = k_dsrav;
      5'h18: r = k_mult;
      5'h19: r = k_multu;
      5'h1a: r = k_div;
      5'h1b: r = k_divu;
      5'h1c: r = k_dmult;
      5'h1d: r = k_dmultu;
      5'h1e: r = k_ddiv;
      default: r = k_ddivu;
    endcase
    return r;
  endfunction : decode_reg_reg

  // imm8_group
  // codes 100 and 110 are holes and fall through to the default
  function automatic operation_e decode_imm8(input logic [15:0] h);
    operation_e r;
    case (h[FIRST_HI:FIRST_LO])
      3'h0: r = k_bteqz;
      3'h1: r = k_btnez;
      3'h2: r = k_sw_ra_sp;
      3'h3: r = k_adj_sp;
      3'h5: r = k_move_into_full_reg;
      3'h7: r = k_move_from_full_reg;
      default: r = k_reserved;         // codes 100 and 110
    endcase
    return r;
  endfunction : decode_imm8

  // imm64_group, 64-bit only
  // every code here is 64-bit only; the gate in the decode process turns
  // them into reserved when the extended mode is off
  function automatic operation_e decode_imm64(input logic [15:0] h);
    operation_e r;
    case (h[FIRST_HI:FIRST_LO])
      3'h0: r = k_ld_sp;
      3'h1: r = k_sd_sp;
      3'h2: r = k_sd_ra_sp;
      3'h3: r = k_dadj_sp;
      3'h4: r = k_ld_pc;
      3'h5: r = k_dword_add_imm_second;
      3'h6: r = k_daddiu_pc;
      default: r = k_daddiu_sp;
    endcase
    return r;
  endfunction : decode_imm64

  // ======================================================================
  // major map, 5-bit code = {row, column}
  // nested functions keep each minor map a flat table that can be read
  // against the encoding without tracing the major decode
  function automatic operation_e decode_major(input logic [15:0] h);
    operation_e r;
    case (h[MAJ_HI:MAJ_LO])
      5'h00: r = k_addiu_sp;
      5'h01: r = k_addiu_pc;
      5'h02: r = k_branch;
      5'h03: r = h[JAL_SEL] ? k_jalx : k_jal;
      5'h04: r = k_beqz;
      5'h05: r = k_bnez;
      5'h06: r = decode_shift(h);
      5'h07: r = k_ld;
      5'h08: r = h[RIA_SEL] ? k_daddiu_ria : k_addiu_ria;
      5'h09: r = k_add_imm_first_reg;
      5'h0a: r = k_slti;
      5'h0b: r = k_sltiu;
      5'h0c: r = decode_imm8(h);
      5'h0d: r = k_li;
      5'h0e: r = k_cmpi;
      5'h0f: r = k_sd;
      5'h10: r = k_lb;
      5'h11: r = k_lh;
      5'h12: r = k_lw_sp;
      5'h13: r = k_lw;
      5'h14: r = k_lbu;
      5'h15: r = k_lhu;
      5'h16: r = k_lw_pc;
      5'h17: r = k_lwu;
      5'h18: r = k_sb;
      5'h19: r = k_sh;
      5'h1a: r = k_sw_sp;
      5'h1b: r = k_sw;
      5'h1c: r = decode_three_reg(h);
      5'h1d: r = decode_reg_reg(h);
      5'h1e: r = k_extend;
      default: r = decode_imm64(h);
    endcase
    return r;
  endfunction : decode_major

  // operations that exist only in the extended 64-bit instruction set
  // the list must match the extended set exactly: a missing entry lets a
  // 64-bit operation run while the extended mode is off
  function automatic logic is_dword(input operation_e o);
    case (o)
      k_dsll, k_ld, k_daddiu_ria, k_sd, k_lwu, k_daddu, k_dsubu,
      k_dsrl, k_dsra, k_dsllv, k_dsrlv, k_dsrav,
      k_dmult, k_dmultu, k_ddiv, k_ddivu,
      k_ld_sp, k_sd_sp, k_sd_ra_sp, k_dadj_sp,
      k_ld_pc, k_dword_add_imm_second, k_daddiu_pc, k_daddiu_sp: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_dword

  // zero count field means a shift of eight
  // the shift group and the two constant dword shifts both use this mapping;
  // the dword shifts take the count from the first field, not the shift field
  function automatic logic [3:0] shift_amount(input logic [2:0] f);
    return (f == 3'h0) ? SHIFT_ZERO_AS : {1'b0, f};
  endfunction : shift_amount

  // ======================================================================
  // state
  dec_state_s state_q;
  dec_state_s state_d;
  operation_e raw_op;

  // combinational decode of the presented halfword
  always_comb begin
    raw_op  = decode_major(fetch_half);
    // start from the reset image so idle slots and unused fields read zero
    state_d = DEC_RESET;
    state_d.valid = fetch_valid;
    if (fetch_valid) begin
      state_d.operation = raw_op;
      // 64-bit-only codes trap when the extended mode is off
      if (is_dword(raw_op) && !mode64_en) begin
        state_d.operation = k_reserved;
      end
      state_d.rsvd_exc = (state_d.operation == k_reserved);
      state_d.invalid  = (state_d.operation == k_invalid);
      state_d.mode_switch = (state_d.operation == k_jalx);
      case (state_d.operation)
        // first field carries the count for the two constant dword shifts
        k_dsrl, k_dsra: begin
          state_d.shift_count = shift_amount(fetch_half[FIRST_HI:FIRST_LO]);
          state_d.dshift_ext_layout = 1'b1;
        end
        k_sll, k_dsll, k_srl, k_sra: begin
          state_d.shift_count = shift_amount(fetch_half[SHAMT_HI:SHAMT_LO]);
        end
        // scrambled 5-bit target: low three bits sit above the high two
        k_move_into_full_reg: begin
          state_d.full_reg = {fetch_half[FULL_HI_HI:FULL_HI_LO],
                              fetch_half[SECOND_HI:SECOND_LO]};
        end
        k_move_from_full_reg: begin
          state_d.full_reg = fetch_half[FULL_SRC_HI:FULL_SRC_LO];
        end
        default: begin
          state_d.full_reg = 5'h00;
        end
      endcase
    end
  end

  // one register stage; outputs come straight from it, costing a cycle
  // fetch sees no back-pressure, so this stage never stalls
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DEC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // output drive
  // each port mirrors one field of the registered state
  assign dec_valid_q       = state_q.valid;
  assign dec_operation_q   = state_q.operation;
  assign dec_rsvd_exc_q    = state_q.rsvd_exc;
  assign dec_invalid_q     = state_q.invalid;
  assign dec_full_reg_q    = state_q.full_reg;
  assign dec_shift_count_q = state_q.shift_count;
  assign dec_dshift_ext_q  = state_q.dshift_ext_layout;
  assign dec_mode_switch_q = state_q.mode_switch;

endmodule : halfword_decoder

//--- pkg/halfword_decode_pkg.sv
/*
  shared types and constants for the compact halfword instruction decoder:
  field positions, operation identifiers and the registered result struct.
  assumes a single pipeline clock and no software-visible registers.
*/
package halfword_decode_pkg;

  // =====================================================================
  // field positions inside the 16-bit halfword
  localparam int unsigned MAJ_HI      = 15;  // major_opcode row+column
  localparam int unsigned MAJ_LO      = 11;
  localparam int unsigned FIRST_HI    = 10;  // first register field
  localparam int unsigned FIRST_LO    = 8;
  localparam int unsigned SECOND_HI   = 7;   // second_reg_field
  localparam int unsigned SECOND_LO   = 5;
  localparam int unsigned SHAMT_HI    = 4;   // shift group count field
  localparam int unsigned SHAMT_LO    = 2;
  localparam int unsigned FUNCT_HI    = 4;   // reg_reg_group function field
  localparam int unsigned FUNCT_LO    = 0;
  localparam int unsigned SUB2_HI     = 1;   // two-bit minor selector
  localparam int unsigned SUB2_LO     = 0;
  localparam int unsigned RIA_SEL     = 4;   // reg_imm_add_group selector
  localparam int unsigned JAL_SEL     = 10;  // mode-switching selector
  localparam int unsigned FULL_HI_HI  = 4;   // move_into_full_reg r[4:3]
  localparam int unsigned FULL_HI_LO  = 3;
  localparam int unsigned FULL_SRC_HI = 4;   // move_from_full_reg source
  localparam int unsigned FULL_SRC_LO = 0;

  // shift count of zero stands for eight
  localparam logic [3:0]  SHIFT_ZERO_AS = 4'h8;
  localparam logic [15:0] HALF_RESET    = 16'h0000;

  // =====================================================================
  // operation identifiers
  typedef enum logic [6:0] {
    k_none        = 7'h00, k_reserved    = 7'h01, k_invalid     = 7'h02,
    k_addiu_sp    = 7'h03, k_addiu_pc    = 7'h04, k_branch      = 7'h05,
    k_jal         = 7'h06, k_jalx        = 7'h07, k_beqz        = 7'h08,
    k_bnez        = 7'h09, k_sll         = 7'h0a, k_dsll        = 7'h0b,
    k_srl         = 7'h0c, k_sra         = 7'h0d, k_ld          = 7'h0e,
    k_addiu_ria   = 7'h0f, k_daddiu_ria  = 7'h10, k_add_imm_first_reg = 7'h11,
    k_slti        = 7'h12, k_sltiu       = 7'h13, k_li          = 7'h14,
    k_cmpi        = 7'h15, k_sd          = 7'h16, k_lb          = 7'h17,
    k_lh          = 7'h18, k_lw_sp       = 7'h19, k_lw          = 7'h1a,
    k_lbu         = 7'h1b, k_lhu         = 7'h1c, k_lw_pc       = 7'h1d,
    k_lwu         = 7'h1e, k_sb          = 7'h1f, k_sh          = 7'h20,
    k_sw_sp       = 7'h21, k_sw          = 7'h22, k_daddu       = 7'h23,
    k_addu        = 7'h24, k_dsubu       = 7'h25, k_subu        = 7'h26,
    k_extend      = 7'h27, k_jump_first  = 7'h28, k_jump_ret    = 7'h29,
    k_jump_link   = 7'h2a, k_slt         = 7'h2b, k_sltu        = 7'h2c,
    k_sllv        = 7'h2d, k_brk         = 7'h2e, k_srlv        = 7'h2f,
    k_srav        = 7'h30, k_dsrl        = 7'h31, k_cmp         = 7'h32,
    k_neg         = 7'h33, k_and         = 7'h34, k_or          = 7'h35,
    k_xor         = 7'h36, k_not         = 7'h37, k_mfhi        = 7'h38,
    k_mflo        = 7'h39, k_dsra        = 7'h3a, k_dsllv       = 7'h3b,
    k_dsrlv       = 7'h3c, k_dsrav       = 7'h3d, k_mult        = 7'h3e,
    k_multu       = 7'h3f, k_div         = 7'h40, k_divu        = 7'h41,
    k_dmult       = 7'h42, k_dmultu      = 7'h43, k_ddiv        = 7'h44,
    k_ddivu       = 7'h45, k_bteqz       = 7'h46, k_btnez       = 7'h47,
    k_sw_ra_sp    = 7'h48, k_adj_sp      = 7'h49, k_move_into_full_reg = 7'h4a,
    k_move_from_full_reg = 7'h4b, k_ld_sp = 7'h4c, k_sd_sp      = 7'h4d,
    k_sd_ra_sp    = 7'h4e, k_dadj_sp     = 7'h4f, k_ld_pc       = 7'h50,
    k_dword_add_imm_second = 7'h51, k_daddiu_pc = 7'h52, k_daddiu_sp = 7'h53
  } operation_e;

  // registered decode result, also the whole state of the decoder
  typedef struct packed {
    logic       valid;
    operation_e operation;
    logic       rsvd_exc;
    logic       invalid;
    logic [4:0] full_reg;
    logic [3:0] shift_count;
    logic       dshift_ext_layout;
    logic       mode_switch;
  } dec_state_s;

  localparam dec_state_s DEC_RESET = '{
    valid: 1'b0, operation: k_none, rsvd_exc: 1'b0, invalid: 1'b0,
    full_reg: 5'h00, shift_count: 4'h0, dshift_ext_layout: 1'b0,
    mode_switch: 1'b0};

endpackage : halfword_decode_pkg
